// File: rtl/vtar_regs.sv
// vtar_regs: vlan and port default vid table access register bank with
// aging-test control, a classic wishbone slave and frame-side lookups.
// assumes one 40 MHz clock, synchronous reset, and a frame classifier that
// presents one received frame's port and vid per cycle.
`timescale 1ns/10ps
module vtar_regs #(
  parameter int     NUM_VLANS = 16,
  parameter int     NUM_PORTS = 3,
  parameter longint AGE_NORMAL_CY = vtar_pkg::AGE_NORMAL_CY,
  parameter longint AGE_TEST_CY   = vtar_pkg::AGE_TEST_CY
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [17:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // frame classifier side
  input  wire logic        frm_valid_i,
  input  wire logic [1:0]  frm_port_i,
  input  wire logic        frm_tagged_i,
  input  wire logic [11:0] frm_vid_i,
  input  wire logic [2:0]  frm_pri_i,
  input  wire logic [2:0]  admit_nonmember_i,
  input  wire logic [2:0]  egress_hybrid_i,
  // frame decisions
  output logic             frm_admit_o,
  output logic [11:0]      frm_eff_vid_o,
  output logic [2:0]       frm_eff_pri_o,
  output logic [2:0]       frm_egress_mask_o,
  output logic [2:0]       frm_strip_mask_o,
  // aging
  output logic             age_tick_o
);

  initial begin
    if (NUM_VLANS < 1 || NUM_VLANS > 16) $error("vlan count must be 1..16");
    if (NUM_PORTS != 3) $error("port count must be 3");
  end

  localparam int DW = vtar_pkg::DATA_W;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic          age_test_ff;
  logic [5:0]    cmd_ff;
  logic [DW-1:0] wdata_ff;
  logic [DW-1:0] rdata_ff;
  logic [DW-1:0] nxt_rdata;
  logic          pend_ff;
  logic [1:0]    acc_cnt_ff;
  logic [14:0]   port_default_vid_ff [3];
  // effective frame tag fields; the vid is read by every entry's lookup
  logic [11:0]   frm_eff_vid;
  logic [2:0]    frm_eff_pri;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire        req     = cyc_i & stb_i & ~ack_o;
  wire [15:0] idx     = adr_i[17:2];
  wire        wr_lo   = req & we_i & sel_i[0];
  wire        wr_age  = wr_lo & (idx == vtar_pkg::IDX_AGING_CFG);
  // only byte lane 0 launches a command, so bit 5 and the index arrive together
  wire        wr_cmd  = wr_lo & (idx == vtar_pkg::IDX_VLAN_CMD);
  wire        wr_wdat = req & we_i & (idx == vtar_pkg::IDX_WR_DATA);
  wire        cmd_rnw = cmd_ff[vtar_pkg::CMD_RNW_BIT];
  wire        cmd_pv  = cmd_ff[vtar_pkg::CMD_TSEL_BIT];
  wire [3:0]  cmd_idx = cmd_ff[vtar_pkg::CMD_IDX_MSB:0];
  wire        acc_end = pend_ff & (acc_cnt_ff == 2'(vtar_pkg::ACCESS_CY - 1));
  wire        do_wr   = acc_end & ~cmd_rnw;
  wire        do_rd   = acc_end & cmd_rnw;

  // ----------------------------------------------------------------------
  // vlan entries
  // ----------------------------------------------------------------------
  logic [DW-1:0] ent   [NUM_VLANS];
  logic          hit   [NUM_VLANS];
  logic          memb  [NUM_VLANS];
  logic          untag [NUM_VLANS];
  logic [2:0]    mset  [NUM_VLANS];

  for (genvar g = 0; g < NUM_VLANS; g++) begin : g_ent
    vtar_vlan_entry #(.W(DW)) u_ent (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .we_i      (do_wr & ~cmd_pv & (cmd_idx == 4'(g))),
      .wdata_i   (wdata_ff),
      .vid_i     (frm_eff_vid),
      .port_i    (frm_port_i),
      .entry_o   (ent[g]),
      .hit_o     (hit[g]),
      .member_o  (memb[g]),
      .untag_o   (untag[g]),
      .members_o (mset[g])
    );
  end

  // ----------------------------------------------------------------------
  // frame lookup
  // ----------------------------------------------------------------------
  logic        any_hit;
  logic        hit_memb;
  logic        hit_untag;
  logic [2:0]  hit_mset;
  logic [14:0] port_def;

  assign port_def = (frm_port_i < 2'd3) ? port_default_vid_ff[frm_port_i] : 15'h0000;

  always_comb begin
    // untagged or null-vid frames take the port defaults
    if (!frm_tagged_i || frm_vid_i == vtar_pkg::NULL_VID) begin
      frm_eff_vid = port_def[vtar_pkg::VID_MSB:0];
      frm_eff_pri = port_def[vtar_pkg::PRI_MSB:vtar_pkg::PRI_LSB];
    end else begin
      frm_eff_vid = frm_vid_i;
      frm_eff_pri = frm_pri_i;
    end
  end

  // lowest-numbered matching entry wins if software programs duplicates
  always_comb begin
    any_hit   = 1'b0;
    hit_memb  = 1'b0;
    hit_untag = 1'b0;
    hit_mset  = 3'h0;
    for (int i = NUM_VLANS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        any_hit   = 1'b1;
        hit_memb  = memb[i];
        hit_untag = untag[i];
        hit_mset  = mset[i];
      end
    end
  end

  // non-member ingress drops unless admit-nonmember is set for the port
  wire adm_nm    = (frm_port_i < 2'd3) ? admit_nonmember_i[frm_port_i] : 1'b0;
  wire nxt_admit = frm_valid_i & (~any_hit | hit_memb | adm_nm);
  wire [2:0] nxt_egress = any_hit ? hit_mset : 3'h7;
  wire [2:0] nxt_strip  = (any_hit & hit_untag) ? (egress_hybrid_i & hit_mset)
                                                : 3'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frm_admit_o       <= 1'b0;
      frm_eff_vid_o     <= 12'h000;
      frm_eff_pri_o     <= 3'h0;
      frm_egress_mask_o <= 3'h0;
      frm_strip_mask_o  <= 3'h0;
    end else begin
      frm_admit_o       <= nxt_admit;
      frm_eff_vid_o     <= frm_eff_vid;
      frm_eff_pri_o     <= frm_eff_pri;
      frm_egress_mask_o <= frm_valid_i ? nxt_egress : 3'h0;
      frm_strip_mask_o  <= frm_valid_i ? nxt_strip : 3'h0;
    end
  end

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_ff     <= vtar_pkg::CMD_RST;
      pend_ff    <= 1'b0;
      acc_cnt_ff <= 2'h0;
    end else if (wr_cmd) begin
      // a new command restarts any access in flight
      cmd_ff     <= dat_i[5:0];
      pend_ff    <= 1'b1;
      acc_cnt_ff <= 2'h0;
    end else if (acc_end) begin
      pend_ff    <= 1'b0;
      acc_cnt_ff <= 2'h0;
    end else if (pend_ff) begin
      acc_cnt_ff <= acc_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdata_ff    <= vtar_pkg::WDATA_RST;
      age_test_ff <= 1'b0;
    end else begin
      // lane 2 carries only the two top entry bits
      if (wr_wdat && sel_i[0]) wdata_ff[7:0]   <= dat_i[7:0];
      if (wr_wdat && sel_i[1]) wdata_ff[15:8]  <= dat_i[15:8];
      if (wr_wdat && sel_i[2]) wdata_ff[17:16] <= dat_i[17:16];
      if (wr_age) age_test_ff <= dat_i[vtar_pkg::AGE_TEST_BIT];
    end
  end

  // port default table: reserved bits are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < 3; p++) port_default_vid_ff[p] <= 15'h0000;
    end else if (do_wr && cmd_pv && cmd_idx < 4'd3) begin
      port_default_vid_ff[cmd_idx[1:0]] <= wdata_ff[vtar_pkg::PRI_MSB:0];
    end
  end

  always_comb begin
    nxt_rdata = rdata_ff;
    if (do_rd) begin
      if (cmd_pv) begin
        nxt_rdata = (cmd_idx < 4'd3) ? {3'h0, port_default_vid_ff[cmd_idx[1:0]]} : '0;
      end else begin
        // one extra bit so that a full table of 16 entries compares correctly
        nxt_rdata = ({1'b0, cmd_idx} < 5'(NUM_VLANS)) ? ent[cmd_idx] : '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) rdata_ff <= '0;
    else       rdata_ff <= nxt_rdata;
  end

  // ----------------------------------------------------------------------
  // bus read mux and acknowledge
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    unique case (idx)
      vtar_pkg::IDX_AGING_CFG:  rd_mux = {31'h0, age_test_ff};
      vtar_pkg::IDX_VLAN_CMD:   rd_mux = {26'h0, cmd_ff};
      vtar_pkg::IDX_WR_DATA:    rd_mux = {14'h0, wdata_ff};
      vtar_pkg::IDX_CMD_STATUS: rd_mux = {31'h0, pend_ff};
      vtar_pkg::IDX_RD_DATA:    rd_mux = {14'h0, rdata_ff};
      default:                  rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= req;
      dat_o <= (req & ~we_i) ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // aging timer
  // ----------------------------------------------------------------------
  vtar_age_timer #(
    .NORMAL_CY (AGE_NORMAL_CY),
    .TEST_CY   (AGE_TEST_CY)
  ) u_age (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .age_test_i (age_test_ff),
    .tick_o     (age_tick_o)
  );

endmodule : vtar_regs

// File: rtl/vtar_pkg.sv
// vtar_pkg: register map, field layout, reset values and timing for the
// vlan table access register bank.
// assumes a 40 MHz core clock and word-indexed register offsets.
package vtar_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_AGING_CFG  = 16'h1809;
  localparam logic [15:0] IDX_VLAN_CMD   = 16'h180b;
  localparam logic [15:0] IDX_CMD_STATUS = 16'h180d;
  localparam logic [15:0] IDX_WR_DATA    = 16'h180c;
  localparam logic [15:0] IDX_RD_DATA    = 16'h180e;
  localparam int          ADDR_W         = 18;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int AGE_TEST_BIT   = 0;
  localparam int CMD_RNW_BIT    = 5;
  localparam int CMD_TSEL_BIT   = 4;
  localparam int CMD_IDX_MSB    = 3;
  localparam int PEND_BIT       = 0;
  localparam int DATA_W         = 18;
  localparam int VID_MSB        = 11;
  localparam int PRI_LSB        = 12;
  localparam int PRI_MSB        = 14;
  localparam int PORT_BITS_LSB  = 12;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [5:0]        CMD_RST   = 6'h00;
  localparam logic [DATA_W-1:0] WDATA_RST = 18'h00000;
  localparam logic [11:0]       NULL_VID  = 12'h000;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ        = 40000000;
  localparam longint AGE_NORMAL_S  = 300;
  localparam longint AGE_TEST_MS   = 50;
  localparam longint AGE_NORMAL_CY = AGE_NORMAL_S * CLK_HZ;
  localparam longint AGE_TEST_CY   = AGE_TEST_MS * CLK_HZ / 1000;
  localparam int     ACCESS_CY     = 2;

endpackage : vtar_pkg

// File: rtl/vtar_age_timer.sv
// vtar_age_timer: lookup table aging tick generator.
// assumes the caller consumes a one-cycle tick each time the interval ends.
`timescale 1ns/10ps
module vtar_age_timer #(
  parameter longint NORMAL_CY = 64'd12000000000,
  parameter longint TEST_CY   = 64'd2000000
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic age_test_i,
  // tick
  output logic      tick_o
);

  initial begin
    if (TEST_CY < 1 || NORMAL_CY < TEST_CY) $error("bad aging counts");
  end

  logic [39:0] cnt_ff;
  logic [39:0] limit;
  logic        at_end;

  // a change of mode restarts nothing; the new limit applies at once
  assign limit  = age_test_i ? 40'(TEST_CY - 1) : 40'(NORMAL_CY - 1);
  assign at_end = (cnt_ff >= limit);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 40'h0;
      tick_o <= 1'b0;
    end else begin
      cnt_ff <= at_end ? 40'h0 : cnt_ff + 40'h1;
      tick_o <= at_end;
    end
  end

endmodule : vtar_age_timer

// File: rtl/vtar_vlan_entry.sv
// vtar_vlan_entry: one vlan membership entry and its frame-side decode.
// assumes the port index and frame vid come from the classifier each cycle.
`timescale 1ns/10ps
module vtar_vlan_entry #(
  parameter int W = 18
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // write side
  input  wire logic         we_i,
  input  wire logic [W-1:0] wdata_i,
  // lookup side
  input  wire logic [11:0]  vid_i,
  input  wire logic [1:0]   port_i,
  output logic [W-1:0]      entry_o,
  output logic              hit_o,
  output logic              member_o,
  output logic              untag_o,
  output logic [2:0]        members_o
);

  initial begin
    if (W != 18) $error("vlan entry width must be 18");
  end

  logic [W-1:0] ent_ff;
  logic [5:0]   pbits;

  always_ff @(posedge clk_i) begin
    if (rst_i) ent_ff <= '0;
    else if (we_i) ent_ff <= wdata_i;
  end

  // pairs are {member,untag} for port 2, 1, 0 from bit 17 down
  assign pbits     = ent_ff[17:12];
  assign entry_o   = ent_ff;
  // a null identifier disables the entry
  assign hit_o     = (ent_ff[11:0] != 12'h000) && (ent_ff[11:0] == vid_i);
  assign members_o = {pbits[5], pbits[3], pbits[1]};
  assign member_o  = pbits[2*port_i + 1];
  assign untag_o   = pbits[2*port_i];

endmodule : vtar_vlan_entry

// File: verification/vtar_regs_chk.sv
// vtar_regs_chk: port-level checks for the vlan table access register bank.
// assumes it is bound to every vtar_regs instance and sees only its ports.
`timescale 1ns/10ps
module vtar_regs_chk #(
  parameter longint AGE_TEST_CY = 10
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // frame side
  input wire logic        frm_valid_i,
  input wire logic        frm_tagged_i,
  input wire logic [11:0] frm_vid_i,
  input wire logic [2:0]  frm_pri_i,
  input wire logic [2:0]  egress_hybrid_i,
  input wire logic        frm_admit_o,
  input wire logic [11:0] frm_eff_vid_o,
  input wire logic [2:0]  frm_eff_pri_o,
  input wire logic [2:0]  frm_egress_mask_o,
  input wire logic [2:0]  frm_strip_mask_o,
  // aging
  input wire logic        age_tick_o
);
  // ----------------------------------------------------------------------
  // helper: cycles since the last aging tick
  // ----------------------------------------------------------------------
  // wide enough for the normal interval, so the count never wraps
  logic [39:0] gap_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || age_tick_o) gap_ff <= 40'h0;
    else gap_ff <= gap_ff + 40'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && !age_tick_o && frm_egress_mask_o == 3'h0)
    else $error("outputs active after reset");
  AST_TICK_GAP: assert property (age_tick_o |-> gap_ff >= AGE_TEST_CY - 1)
    else $error("aging ticks too close");
  AST_IDLE_MASK: assert property (!frm_valid_i |=>
    frm_egress_mask_o == 3'h0 && frm_strip_mask_o == 3'h0)
    else $error("masks set without a frame");
  AST_STRIP_SUB: assert property (##1
    (frm_strip_mask_o & ~(frm_egress_mask_o & $past(egress_hybrid_i))) == 3'h0)
    else $error("strip outside hybrid members");
  AST_TAG_VID: assert property (frm_valid_i && frm_tagged_i && frm_vid_i != 12'h000
    |=> frm_eff_vid_o == $past(frm_vid_i) && frm_eff_pri_o == $past(frm_pri_i))
    else $error("tagged vid not passed through");

  cover property (ack_o);
  cover property (age_tick_o);
  cover property (frm_valid_i ##1 !frm_admit_o);
  cover property (frm_strip_mask_o != 3'h0);
endmodule : vtar_regs_chk

bind vtar_regs vtar_regs_chk #(.AGE_TEST_CY(AGE_TEST_CY)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
  .ack_o(ack_o), .frm_valid_i(frm_valid_i), .frm_tagged_i(frm_tagged_i),
  .frm_vid_i(frm_vid_i), .frm_pri_i(frm_pri_i), .egress_hybrid_i(egress_hybrid_i),
  .frm_admit_o(frm_admit_o), .frm_eff_vid_o(frm_eff_vid_o),
  .frm_eff_pri_o(frm_eff_pri_o), .frm_egress_mask_o(frm_egress_mask_o),
  .frm_strip_mask_o(frm_strip_mask_o), .age_tick_o(age_tick_o));

// File: verification/tb_top.sv
// tb_top: directed wishbone and frame tests of the vlan table register bank.
// assumes short aging parameters (100 and 10 cycles) set on the instance.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  localparam logic [15:0] AG = vtar_pkg::IDX_AGING_CFG;
  localparam logic [15:0] CM = vtar_pkg::IDX_VLAN_CMD;
  localparam logic [15:0] ST = vtar_pkg::IDX_CMD_STATUS;
  localparam logic [15:0] WD = vtar_pkg::IDX_WR_DATA;
  localparam logic [15:0] RD = vtar_pkg::IDX_RD_DATA;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [17:0] adr = 18'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dout, q;
  logic fv = 1'b0, ft = 1'b0, adm, tick;
  logic [1:0] fp = 2'h0;
  logic [11:0] fvid = 12'h0, evid;
  logic [2:0] fpri = 3'h2, anm = 3'h0, hyb = 3'h7, epri, eg, es;
  int n_fail = 0, n_checks = 0, cyc_n = 0, g;

  always #12.5 clk = ~clk;

  vtar_regs #(.AGE_NORMAL_CY(100), .AGE_TEST_CY(10)) i_dut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dout), .ack_o(ack), .frm_valid_i(fv),
    .frm_port_i(fp), .frm_tagged_i(ft), .frm_vid_i(fvid), .frm_pri_i(fpri),
    .admit_nonmember_i(anm), .egress_hybrid_i(hyb), .frm_admit_o(adm),
    .frm_eff_vid_o(evid), .frm_eff_pri_o(epri), .frm_egress_mask_o(eg),
    .frm_strip_mask_o(es), .age_tick_o(tick));

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      n_fail++;
      close_out();
    end
  end

  // one classic cycle; entered just after a rising edge
  task automatic xf(input logic w, input logic [15:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {a, 2'b00}; dat <= d; sel <= 4'hf;
    // no cycle count assumed: only the hang guard ends this wait
    do @(posedge clk); while (ack !== 1'b1);
    q = dout;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask : xf

  task automatic cmd(input logic [5:0] c);
    int k;
    xf(1'b1, CM, {26'h0, c});
    k = 0;
    do begin xf(1'b0, ST, 32'h0); k++; end while (q[0] !== 1'b0 && k < 20);
    if (k >= 20) begin
      n_fail++;
      close_out();
    end
  endtask : cmd

  task automatic tbl(input logic t, input logic [3:0] i, input logic [31:0] exp);
    cmd({1'b1, t, i});
    xf(1'b0, RD, 32'h0);
    `CHK(q, exp)
  endtask : tbl

  task automatic fr(input logic [1:0] p, input logic t, input logic [11:0] v,
                    input logic [21:0] exp);
    fv <= 1'b1; fp <= p; ft <= t; fvid <= v;
    @(posedge clk);
    fv <= 1'b0;
    #1;
    `CHK({adm, eg, es, evid, epri}, exp)
    @(posedge clk);
  endtask : fr

  task automatic gap(output int n);
    n = 0;
    do @(posedge clk); while (tick !== 1'b1);
    do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 300);
  endtask : gap

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // ----------------------------------------------------------------------
    // reset values and the unmapped hole
    // ----------------------------------------------------------------------
    xf(1'b0, AG, 0); `CHK(q, 32'h0)
    xf(1'b0, CM, 0); `CHK(q, 32'h0)
    xf(1'b0, WD, 0); `CHK(q, 32'h0)
    xf(1'b0, 16'h1800, 0); `CHK(q, 32'h0)
    for (int p = 0; p < 3; p++) tbl(1'b1, p[3:0], 32'h0);
    $display("test reset done");
    // ----------------------------------------------------------------------
    // table writes and read-back; reserved bit 15 of a port entry dropped
    // ----------------------------------------------------------------------
    xf(1'b1, WD, 32'h0d123); cmd(6'h11);
    xf(1'b0, CM, 0); `CHK(q, 32'h11)
    tbl(1'b1, 4'h1, 32'h5123);
    tbl(1'b0, 4'h1, 32'h0);
    xf(1'b1, WD, 32'h3200a); cmd(6'h02);
    tbl(1'b0, 4'h2, 32'h3200a);
    xf(1'b1, WD, 32'h0000b); cmd(6'h00);
    $display("test table done");
    // ----------------------------------------------------------------------
    // frames: fields {admit, egress, strip, vid, pri}
    // ----------------------------------------------------------------------
    fr(2'd2, 1'b1, 12'h00a, {1'b1, 3'h5, 3'h5, 12'h00a, 3'h2});
    fr(2'd1, 1'b1, 12'h00a, {1'b0, 3'h5, 3'h0, 12'h00a, 3'h2});
    anm <= 3'h2; hyb <= 3'h1;
    fr(2'd1, 1'b1, 12'h00a, {1'b1, 3'h5, 3'h0, 12'h00a, 3'h2});
    fr(2'd2, 1'b1, 12'h00a, {1'b1, 3'h5, 3'h1, 12'h00a, 3'h2});
    fr(2'd1, 1'b0, 12'h00a, {1'b1, 3'h7, 3'h0, 12'h123, 3'h5});
    fr(2'd1, 1'b1, 12'h000, {1'b1, 3'h7, 3'h0, 12'h123, 3'h5});
    fr(2'd0, 1'b1, 12'h00b, {1'b0, 3'h0, 3'h0, 12'h00b, 3'h2});
    xf(1'b1, WD, 32'h0); cmd(6'h00);
    fr(2'd0, 1'b1, 12'h00b, {1'b1, 3'h7, 3'h0, 12'h00b, 3'h2});
    $display("test frames done");
    // ----------------------------------------------------------------------
    // aging interval, normal then test
    // ----------------------------------------------------------------------
    gap(g); `CHK(g, 100)
    xf(1'b1, AG, 32'h1); xf(1'b0, AG, 0); `CHK(q, 32'h1)
    gap(g); gap(g); `CHK(g, 10)
    $display("test aging done");
    close_out();
  end
endmodule : tb_top
